// [common/mcrb_defs.svh]
`ifndef MCRB_DEFS_SVH
`define MCRB_DEFS_SVH

// Register addresses (3-bit bus address)
`define MCRB_ADDR_CTRL1      3'h1
`define MCRB_ADDR_CTRL2      3'h4
`define MCRB_ADDR_CTRL3      3'h5
`define MCRB_ADDR_SIG        3'h6

// Field positions
`define MCRB_CR1_PAT_HI      7
`define MCRB_CR1_PAT_LO      6
`define MCRB_CR2_SPEC_BIT    6
`define MCRB_CR3_ALT_BIT     7
`define MCRB_CR3_TRI_BIT     6
`define MCRB_CR3_BOOST_BIT   4
`define MCRB_CR3_ATT_HI      3
`define MCRB_EXT_SRC_BIT     3
`define MCRB_EXT_SQ_HI       2
`define MCRB_EXT_SQ_LO       1
`define MCRB_EXT_RW_MASK     8'h0F

// Reset values
`define MCRB_CTRL1_RST       8'h00
`define MCRB_CTRL2_RST       8'h00
`define MCRB_CTRL3_RST       8'h04
`define MCRB_EXT_RST         8'h00
`define MCRB_SQ_DEFAULT      2'h0

// Arbitrary identity value, not tied to any product
`define MCRB_SIG_VALUE       8'h50

`endif

// [common/mcrb_pkg.sv]
package mcrb_pkg;

    typedef enum logic [1:0]
    {
        MCRB_PAT_DATA  = 2'h0,
        MCRB_PAT_ALT   = 2'h1,
        MCRB_PAT_MARK  = 2'h2,
        MCRB_PAT_SPACE = 2'h3
    } mcrb_pat_t;

    typedef struct packed
    {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } mcrb_req_t;

    typedef struct packed
    {
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] ctrl3;
        logic [7:0] ext;
        logic [7:0] rdata;
        logic       rvalid;
    } mcrb_state_t;

    typedef struct packed
    {
        logic tx_bit;
        logic alt_phase;
    } mcrb_tx_state_t;

endpackage

// [src/mcrb_tx_select.sv]
`timescale 1ns/1ns
`include "mcrb_defs.svh"

module mcrb_tx_select
    import mcrb_pkg::*;
(
    input  wire logic      CLK,        // System clock
    input  wire logic      SYS_RST,    // Sync reset, high
    input  wire mcrb_pat_t pattern,    // Test pattern select
    input  wire logic      use_alt,    // Register source select
    input  wire logic      alt_bit,    // Register data bit
    input  wire logic      pin_bit,    // Serial pin data
    output logic           tx_bit      // Selected data, registered
);

    mcrb_tx_state_t state_reg;
    mcrb_tx_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        state_next.alt_phase = ~state_reg.alt_phase;
        // Test patterns outrank both data sources
        case (pattern)
            MCRB_PAT_ALT:   state_next.tx_bit = state_reg.alt_phase;
            MCRB_PAT_MARK:  state_next.tx_bit = 1'b1;
            MCRB_PAT_SPACE: state_next.tx_bit = 1'b0;
            MCRB_PAT_DATA:  state_next.tx_bit = use_alt ? alt_bit : pin_bit;
            default:        state_next.tx_bit = pin_bit;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            state_reg <= '{tx_bit: 1'b1, alt_phase: 1'b0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign tx_bit = state_reg.tx_bit;

endmodule

// [src/mcrb_reg_bank.sv]
// Contract
// - Special-access bit redirects address to extension
// - Bit 6 one tristates both clock pins
// - Bit 7 is alternate transmit data
// - Extension bit 3 selects transmit source
// - Test pattern overrides both data sources
// - Extension bits 7-4 read-only, 3-0 writable
`timescale 1ns/1ns
`include "mcrb_defs.svh"

module mcrb_reg_bank
    import mcrb_pkg::*;
(
    input  wire logic       CLK,              // System clock, 100 MHz
    input  wire logic       SYS_RST,          // Sync reset, high
    input  wire logic       BUS_WR,           // Write strobe, one cycle
    input  wire logic       BUS_RD,           // Read strobe, one cycle
    input  wire logic [2:0] BUS_ADDR,         // Register address
    input  wire logic [7:0] BUS_WDATA,        // Write data
    input  wire logic       TXD_PIN,          // Serial transmit data input
    input  wire logic       TXBAUD_IN,        // Baud clock status from pump
    input  wire logic       RXUNSCR_IN,       // Unscrambled receive data from pump
    output logic [7:0]      BUS_RDATA,        // Read data
    output logic            BUS_RVALID,       // Read data valid, one cycle
    output logic            TX_DATA,          // Data toward modulator
    output logic [3:0]      TX_LEVEL_CODE,    // Transmit attenuator code
    output logic            RX_GAIN_BOOST,    // Receive boost enable
    output logic [1:0]      SQ_THRESHOLD,     // Signal quality threshold select
    output logic            TRANSMIT_BIT_CLOCK_OUT_OUT,        // Transmit bit clock level
    output logic            TRANSMIT_BIT_CLOCK_OUT_OE_N,       // Transmit clock enable, low drives
    output logic            RECEIVE_BIT_CLOCK_OUT_OUT,        // Receive bit clock level
    output logic            RECEIVE_BIT_CLOCK_OUT_OE_N        // Receive clock enable, low drives
);

    mcrb_req_t   req;
    mcrb_state_t state_reg;
    mcrb_state_t state_next;
    logic        spec_sel;
    logic        tx_sel;
    logic        tri_reg;
    logic        tri_next;
    logic        bclk_reg;

    assign req = '{wr: BUS_WR, rd: BUS_RD, addr: BUS_ADDR, wdata: BUS_WDATA};
    assign spec_sel = state_reg.ctrl2[`MCRB_CR2_SPEC_BIT];

    always_comb
    begin
        state_next = state_reg;
        state_next.rvalid = 1'b0;
        if (req.wr)
        begin
            case (req.addr)
                `MCRB_ADDR_CTRL1: state_next.ctrl1 = req.wdata;
                `MCRB_ADDR_CTRL2: state_next.ctrl2 = req.wdata;
                `MCRB_ADDR_CTRL3:
                begin
                    if (spec_sel)
                    begin
                        // Only low nibble lands; upper bits stay zero
                        state_next.ext = req.wdata & `MCRB_EXT_RW_MASK;
                    end
                    else
                    begin
                        state_next.ctrl3 = req.wdata;
                    end
                end
                // Unmapped and read-only addresses take no write; keeps rvalid pulse intact
                default:
                begin
                    state_next.ctrl1 = state_next.ctrl1;
                end
            endcase
        end
        if (req.rd)
        begin
            state_next.rvalid = 1'b1;
            case (req.addr)
                `MCRB_ADDR_CTRL1: state_next.rdata = state_reg.ctrl1;
                `MCRB_ADDR_CTRL2: state_next.rdata = state_reg.ctrl2;
                `MCRB_ADDR_CTRL3:
                begin
                    if (spec_sel)
                    begin
                        // Bits 6 and 5 reflect live pump status; bits 7 and 4 read zero
                        state_next.rdata = {1'b0, TXBAUD_IN, RXUNSCR_IN, 1'b0,
                                            state_reg.ext[3:0]};
                    end
                    else
                    begin
                        state_next.rdata = state_reg.ctrl3;
                    end
                end
                `MCRB_ADDR_SIG:   state_next.rdata = `MCRB_SIG_VALUE;
                default:          state_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            state_reg <= '{ctrl1: `MCRB_CTRL1_RST, ctrl2: `MCRB_CTRL2_RST,
                           ctrl3: `MCRB_CTRL3_RST, ext: `MCRB_EXT_RST,
                           rdata: 8'h00, rvalid: 1'b0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign tx_sel   = state_reg.ext[`MCRB_EXT_SRC_BIT];
    assign tri_next = state_reg.ctrl3[`MCRB_CR3_TRI_BIT];

    // Enables and a free-running bit clock, all registered
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            tri_reg  <= 1'b0;
            bclk_reg <= 1'b0;
        end
        else
        begin
            tri_reg  <= tri_next;
            bclk_reg <= ~bclk_reg;
        end
    end

    mcrb_tx_select u_tx_select
    (
        .CLK     (CLK),
        .SYS_RST (SYS_RST),
        .pattern (mcrb_pat_t'(state_reg.ctrl1[`MCRB_CR1_PAT_HI:`MCRB_CR1_PAT_LO])),
        .use_alt (tx_sel),
        .alt_bit (state_reg.ctrl3[`MCRB_CR3_ALT_BIT]),
        .pin_bit (TXD_PIN),
        .tx_bit  (TX_DATA)
    );

    assign BUS_RDATA     = state_reg.rdata;
    assign BUS_RVALID    = state_reg.rvalid;
    assign TX_LEVEL_CODE = state_reg.ctrl3[`MCRB_CR3_ATT_HI:0];
    assign RX_GAIN_BOOST = state_reg.ctrl3[`MCRB_CR3_BOOST_BIT];
    assign SQ_THRESHOLD  = state_reg.ext[`MCRB_EXT_SQ_HI:`MCRB_EXT_SQ_LO];
    assign TRANSMIT_BIT_CLOCK_OUT_OUT     = bclk_reg;
    assign RECEIVE_BIT_CLOCK_OUT_OUT     = bclk_reg;
    assign TRANSMIT_BIT_CLOCK_OUT_OE_N    = tri_reg;
    assign RECEIVE_BIT_CLOCK_OUT_OE_N    = tri_reg;

endmodule

// [test/mcrb_reg_bank_properties.sv]
`timescale 1ns/1ns
module mcrb_chk
    import mcrb_pkg::*;
(
    input wire logic       CLK,           // Clock
    input wire logic       SYS_RST,       // Reset
    input wire logic       BUS_WR,        // Write
    input wire logic       BUS_RD,        // Read
    input wire logic [2:0] BUS_ADDR,      // Address
    input wire logic [7:0] BUS_WDATA,     // Write data
    input wire logic       TXBAUD_IN,     // Baud status
    input wire logic       RXUNSCR_IN,    // Rx data
    input wire logic [7:0] BUS_RDATA,     // Read data
    input wire logic       BUS_RVALID,    // Read valid
    input wire logic [3:0] TX_LEVEL_CODE, // Level
    input wire logic [1:0] SQ_THRESHOLD,  // Threshold
    input wire logic       TRANSMIT_BIT_CLOCK_OUT_OE_N,    // Tx clock enable
    input wire logic       RECEIVE_BIT_CLOCK_OUT_OE_N     // Rx clock enable
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    logic spec_reg;
    wire  w5 = BUS_WR && BUS_ADDR == 3'h5;
    // Mirror of the bank-select bit, seen only through bus writes
    always_ff @(posedge CLK)
        spec_reg <= SYS_RST ? 1'h0 : (BUS_WR && BUS_ADDR == 3'h4) ? BUS_WDATA[6] : spec_reg;
    a_read_answer: assert property (BUS_RD |=> BUS_RVALID)
        else $error("read not answered");
    a_single_valid: assert property (!BUS_RD |=> !BUS_RVALID)
        else $error("stray read valid");
    a_ext_read_fields: assert property (BUS_RD && BUS_ADDR == 3'h5 && spec_reg |=>
        BUS_RDATA[7:4] == {1'h0, $past(TXBAUD_IN), $past(RXUNSCR_IN), 1'h0}) else $error("extension status bits");
    a_level_write: assert property (w5 && !spec_reg |=> TX_LEVEL_CODE == $past(BUS_WDATA[3:0]))
        else $error("level code not written");
    a_level_shielded: assert property (w5 && spec_reg |=> $stable(TX_LEVEL_CODE))
        else $error("extension write reached level");
    a_threshold_write: assert property (w5 && spec_reg |=> SQ_THRESHOLD == $past(BUS_WDATA[2:1]))
        else $error("threshold not written");
    a_tristate_follow: assert property (w5 && !spec_reg |=> ##1 TRANSMIT_BIT_CLOCK_OUT_OE_N == $past(BUS_WDATA[6], 2))
        else $error("clock pin enable");
    a_pins_together: assert property (TRANSMIT_BIT_CLOCK_OUT_OE_N == RECEIVE_BIT_CLOCK_OUT_OE_N)
        else $error("clock pins differ");
    a_reset_defaults: assert property ($fell(SYS_RST) |-> TX_LEVEL_CODE == 4'h4 && SQ_THRESHOLD == 2'h0)
        else $error("reset defaults");
endmodule
bind mcrb_reg_bank mcrb_chk u_chk (.CLK, .SYS_RST, .BUS_WR, .BUS_RD, .BUS_ADDR, .BUS_WDATA, .TXBAUD_IN,
    .RXUNSCR_IN, .BUS_RDATA, .BUS_RVALID, .TX_LEVEL_CODE, .SQ_THRESHOLD, .TRANSMIT_BIT_CLOCK_OUT_OE_N, .RECEIVE_BIT_CLOCK_OUT_OE_N);

// [test/mcrb_host.sv]
`timescale 1ns/1ns
module mcrb_host
    import mcrb_pkg::*;
(
    input  wire logic       clk,    // Clock
    input  wire logic [7:0] rdata,  // Read data
    input  wire logic       rvalid, // Read valid
    output logic            wr,     // Write strobe
    output logic            rd,     // Read strobe
    output logic [2:0]      addr,   // Address
    output logic [7:0]      wdata   // Write data
);
    initial {wr, rd, addr, wdata} = 13'h0;
    task automatic write(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'h1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    // Bit 8 of v flags that an answer came within the bound
    task automatic read(input logic [2:0] a, output logic [8:0] v);
        v = 9'h0;
        @(posedge clk);
        rd   <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd <= 1'h0;
        repeat (4)
        begin
            @(posedge clk);
            if (rvalid && !v[8])
                v = {1'h1, rdata};
        end
    endtask
endmodule

// [test/testbench.sv]
`timescale 1ns/1ns
`include "mcrb_defs.svh"
module testbench;
    logic       clk = 1'h0, rst = 1'h1, pin = 1'h0, baud = 1'h0, unscr = 1'h0;
    logic       wr, rd, rvalid, tx, txoe, rxoe, boost, transmit_bit_clock_out, receive_bit_clock_out;
    logic [2:0] addr;
    logic [7:0] wdata, rdata;
    logic [3:0] level;
    logic [1:0] sq;
    logic [8:0] v;
    int         errors = 0, tests_run = 0;
    always #5 clk = ~clk;
    mcrb_host host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata));
    mcrb_reg_bank dut (.CLK(clk), .SYS_RST(rst), .BUS_WR(wr), .BUS_RD(rd), .BUS_ADDR(addr), .BUS_WDATA(wdata),
        .TXD_PIN(pin), .TXBAUD_IN(baud), .RXUNSCR_IN(unscr), .BUS_RDATA(rdata), .BUS_RVALID(rvalid), .TX_DATA(tx),
        .TX_LEVEL_CODE(level), .RX_GAIN_BOOST(boost), .SQ_THRESHOLD(sq), .TRANSMIT_BIT_CLOCK_OUT_OUT(transmit_bit_clock_out), .TRANSMIT_BIT_CLOCK_OUT_OE_N(txoe),
        .RECEIVE_BIT_CLOCK_OUT_OUT(receive_bit_clock_out), .RECEIVE_BIT_CLOCK_OUT_OE_N(rxoe));
    task print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task check(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task rd_chk(input logic [2:0] a, input logic [7:0] exp);
        host.read(a, v);
        check(v, {1'h1, exp});
        if (v[8] !== 1'h1)
            print_verdict();
    endtask
    task test_defaults;
        rd_chk(3'h5, 8'h04);
        rd_chk(3'h6, `MCRB_SIG_VALUE);
        rd_chk(3'h7, 8'h00);
        check(9'(sq), 9'h0);
        $display("defaults done");
    endtask
    task test_ctrl3;
        logic c;
        host.write(3'h5, 8'hC9);
        rd_chk(3'h5, 8'hC9);
        check(9'(level), 9'h9);
        check(9'(boost), 9'h0);
        check(9'({txoe, rxoe}), 9'h3);
        host.write(3'h5, 8'h14);
        repeat (3) @(posedge clk);
        check(9'({txoe, rxoe}), 9'h0);
        check(9'(boost), 9'h1);
        c = transmit_bit_clock_out;
        @(posedge clk);
        check(9'({transmit_bit_clock_out ^ c, receive_bit_clock_out ^ c}), 9'h3);
        $display("control three done");
    endtask
    task test_special;
        baud <= 1'h1;
        host.write(3'h4, 8'h40);
        host.write(3'h5, 8'hF7);
        rd_chk(3'h5, 8'h47);
        check(9'(sq), 9'h3);
        check(9'(level), 9'h4);
        host.write(3'h4, 8'h00);
        rd_chk(3'h5, 8'h14);
        $display("extension done");
    endtask
    task test_source;
        logic b;
        host.write(3'h4, 8'h40);
        host.write(3'h5, 8'h08);
        host.write(3'h4, 8'h00);
        host.write(3'h5, 8'h84);
        // Alternate bit 1, pin 0, so each source is told apart
        for (int p = 0; p < 4; p++)
        begin
            host.write(3'h1, 8'(p << 6));
            repeat (3) @(posedge clk);
            b = tx;
            @(posedge clk);
            check(9'(p == 1 ? tx ^ b : tx), 9'(p != 3));
        end
        host.write(3'h1, 8'h00);
        host.write(3'h4, 8'h40);
        host.write(3'h5, 8'h00);
        repeat (3) @(posedge clk);
        check(9'(tx), 9'h0);
        pin <= 1'h1;
        repeat (3) @(posedge clk);
        check(9'(tx), 9'h1);
        $display("transmit source done");
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        test_defaults();
        test_ctrl3();
        test_special();
        test_source();
        print_verdict();
    end
endmodule
